// file: core/xbp_clkgen.sv
`timescale 1ns/1ps
module xbp_clkgen
  import xbp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Generated clocks
  output logic      master_clock_out,
  output logic      cpu_phase_clock_out
);
  import xbp_pkg::*;

  logic [NCO_W-1:0] acc_r;
  logic [NCO_W-1:0] acc_nxt;
  logic [1:0]       div_r;
  logic [1:0]       div_nxt;
  logic             master_rise;

  // ----------------------------------------------------------------
  // Phase accumulator and divide by three
  // ----------------------------------------------------------------
  assign acc_nxt     = acc_r + MASTER_INC;
  assign master_rise = acc_nxt[NCO_W-1] & ~acc_r[NCO_W-1];
  assign div_nxt     = (div_r == 2'(PHASE_DIV - 1)) ? 2'd0 : div_r + 2'd1;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r               <= '0;
      div_r               <= 2'd0;
      master_clock_out    <= 1'b0;
      cpu_phase_clock_out <= 1'b0;
    end else begin
      acc_r            <= acc_nxt;
      master_clock_out <= acc_nxt[NCO_W-1];                 // [RULE13]
      if (master_rise) begin
        div_r               <= div_nxt;
        cpu_phase_clock_out <= (div_nxt == 2'd0);           // [RULE14]
      end
    end
  end

endmodule

// file: core/xbp_pkg.sv
package xbp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int HI_ADDR_W = 12;
  localparam int BYTE_W    = 8;
  localparam int NUM_PINS  = 3;

  // ----------------------------------------------------------------
  // Pin input index
  // ----------------------------------------------------------------
  localparam int PIN_BUF_DIS = 0;
  localparam int PIN_ACK     = 1;
  localparam int PIN_BUS_REQ = 2;

  // ----------------------------------------------------------------
  // Address window
  // ----------------------------------------------------------------
  localparam logic [3:0] WINDOW_TOP_NIBBLE = 4'hE;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS     = 4.0;
  localparam real MASTER_PERIOD_NS  = 66.6;
  localparam int  NCO_W             = 16;
  localparam logic [NCO_W-1:0] MASTER_INC =
    NCO_W'(int'(65536.0 * CLK_PERIOD_NS / MASTER_PERIOD_NS));
  localparam int  PHASE_DIV         = 3;
  localparam int  LINK_CLK_NS       = 15;
  localparam int  SLOW_PERIOD_NS    = 1000;
  localparam int  SLOW_HIGH_NS      = 400;
  localparam int  SLOW_CNT_W        = 7;
  localparam logic [SLOW_CNT_W-1:0] SLOW_PERIOD_CYC =
    SLOW_CNT_W'(SLOW_PERIOD_NS / LINK_CLK_NS);
  localparam logic [SLOW_CNT_W-1:0] SLOW_HIGH_CYC =
    SLOW_CNT_W'(SLOW_HIGH_NS / LINK_CLK_NS);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [HI_ADDR_W-1:0] HI_ADDR_RST = 12'h000;
  localparam logic [BYTE_W-1:0]    BYTE_RST    = 8'h00;

endpackage

// file: core/xbp_port.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - High address follows processor, held from address strobe fall to next rise.
// RULE2 - High address outputs float while an external party holds the buses.
// RULE3 - Low address byte sits on the muxed lanes during the address strobe.
// RULE4 - Address strobe marks lanes holding an address; boards latch low byte.
// RULE5 - Buffered read strobe marks a processor read cycle.
// RULE6 - Buffered write strobe marks a processor write cycle.
// RULE7 - Buffered data enable from processor, usable for board transceivers.
// RULE8 - Read data latch strobe falls when processor read data is valid.
// RULE9 - Buffer-disable input stops internal data buffers in the E window.
// RULE10 - Buffer-disable input is ignored for addresses outside that window.
// RULE11 - Boards use the window qualifier to drive buffer-disable and own buffers.
// RULE12 - Window qualifier spans one slow clock falling edge to the next.
// RULE13 - Master clock output near 15 MHz, 66.6 ns period.
// RULE14 - 5 MHz clock in phase with processor clock, 33% duty.
// RULE15 - 1 MHz slow clock, 40/60 duty, independent of 5 MHz clock.
// RULE16 - Acknowledge low from a board pulls processor ready low.
// RULE17 - Acknowledge is resynchronised before reaching processor ready.
// RULE18 - Bus request input is passed on to the processor.
// RULE19 - While grant is high, bus outputs float; latch strobe left to boards.
module xbp_port
  import xbp_pkg::*;
(
  // Clocks and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 link_clk,
  // Processor side
  input  wire logic [HI_ADDR_W-1:0] cpu_high_addr,
  input  wire logic [BYTE_W-1:0]    cpu_ad_out,
  input  wire logic                 cpu_ale,
  input  wire logic                 cpu_rd_n,
  input  wire logic                 cpu_wr_n,
  input  wire logic                 cpu_den_n,
  input  wire logic                 cpu_dt_r,
  input  wire logic                 cpu_hold_ack,
  output logic [BYTE_W-1:0]         cpu_ad_in,
  output logic                      cpu_ready,
  output logic                      cpu_hold_req,
  output logic                      int_buf_en,
  // High address
  output logic [HI_ADDR_W-1:0]      buffered_high_addr_o,
  output logic                      buffered_high_addr_oe,
  // Muxed address and data
  input  wire logic [BYTE_W-1:0]    muxed_addr_data_byte_i,
  output logic [BYTE_W-1:0]         muxed_addr_data_byte_o,
  output logic                      muxed_addr_data_byte_oe,
  // Strobes
  output logic                      ale_o,
  output logic                      ale_oe,
  output logic                      rd_strobe_n_o,
  output logic                      rd_strobe_n_oe,
  output logic                      wr_strobe_n_o,
  output logic                      wr_strobe_n_oe,
  output logic                      transceiver_enable_n_o,
  output logic                      transceiver_enable_n_oe,
  output logic                      read_data_latch_strobe_o,
  output logic                      read_data_latch_strobe_oe,
  // Clocks out and window
  output logic                      master_clock_out,
  output logic                      cpu_phase_clock_out,
  output logic                      slow_clock_out,
  output logic                      window_select_qualifier,
  // Board inputs and grant
  input  wire logic                 ext_buffer_disable_in,
  input  wire logic                 external_acknowledge_in,
  input  wire logic                 bus_request_in,
  output logic                      bus_grant_out
);
  import xbp_pkg::*;

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  function automatic logic in_window(input logic [HI_ADDR_W-1:0] a);
    in_window = (a[HI_ADDR_W-1 -: 4] == WINDOW_TOP_NIBBLE);
  endfunction

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_sync;
  logic                ale_d_r;
  logic                rd_d_r;
  logic                win_hit_r;
  logic                win_tgl_r;
  logic [HI_ADDR_W-1:0] hi_addr_r;
  logic                ale_fall;
  logic                rd_end;
  logic                drive;
  logic                lanes_drive;
  logic [BYTE_W-1:0]   lanes_nxt;

  // ----------------------------------------------------------------
  // Board pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw[PIN_BUF_DIS] = ext_buffer_disable_in;
  assign pin_raw[PIN_ACK]     = external_acknowledge_in;
  assign pin_raw[PIN_BUS_REQ] = bus_request_in;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      xbp_sync3 u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d_in  (pin_raw[gi]),
        .q_out (pin_sync[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Clock generation
  // ----------------------------------------------------------------
  xbp_clkgen u_clkgen (
    .clk                 (clk),
    .rst_n               (rst_n),
    .master_clock_out    (master_clock_out),
    .cpu_phase_clock_out (cpu_phase_clock_out)
  );

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  assign ale_fall    = ale_d_r & ~cpu_ale;
  assign rd_end      = rd_d_r & cpu_rd_n;
  assign drive       = ~cpu_hold_ack;                        // [RULE19]
  assign lanes_drive = drive & (cpu_ale | (~cpu_den_n & cpu_dt_r));
  assign lanes_nxt   = cpu_ad_out;                           // [RULE3]

  // ----------------------------------------------------------------
  // Address hold and window hit
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ale_d_r   <= 1'b0;
      rd_d_r    <= 1'b0;
      hi_addr_r <= HI_ADDR_RST;
      win_hit_r <= 1'b0;
      win_tgl_r <= 1'b0;
    end else begin
      ale_d_r <= cpu_ale;
      rd_d_r  <= ~cpu_rd_n;
      if (cpu_ale) begin
        hi_addr_r <= cpu_high_addr;                          // [RULE1]
        win_hit_r <= in_window(cpu_high_addr);
      end
      if (ale_fall && in_window(hi_addr_r)) begin
        win_tgl_r <= ~win_tgl_r;                             // [RULE12]
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buffered_high_addr_o      <= HI_ADDR_RST;
      buffered_high_addr_oe     <= 1'b0;
      muxed_addr_data_byte_o    <= BYTE_RST;
      muxed_addr_data_byte_oe   <= 1'b0;
      ale_o                     <= 1'b0;
      ale_oe                    <= 1'b0;
      rd_strobe_n_o             <= 1'b1;
      rd_strobe_n_oe            <= 1'b0;
      wr_strobe_n_o             <= 1'b1;
      wr_strobe_n_oe            <= 1'b0;
      transceiver_enable_n_o    <= 1'b1;
      transceiver_enable_n_oe   <= 1'b0;
      read_data_latch_strobe_o  <= 1'b0;
      read_data_latch_strobe_oe <= 1'b0;
      bus_grant_out             <= 1'b0;
    end else begin
      buffered_high_addr_o      <= cpu_ale ? cpu_high_addr
                                           : hi_addr_r;      // [RULE1]
      buffered_high_addr_oe     <= drive;                    // [RULE2]
      muxed_addr_data_byte_o    <= lanes_nxt;                // [RULE3]
      muxed_addr_data_byte_oe   <= lanes_drive;              // [RULE19]
      ale_o                     <= cpu_ale;                  // [RULE4]
      ale_oe                    <= drive;
      rd_strobe_n_o             <= cpu_rd_n;                 // [RULE5]
      rd_strobe_n_oe            <= drive;
      wr_strobe_n_o             <= cpu_wr_n;                 // [RULE6]
      wr_strobe_n_oe            <= drive;
      transceiver_enable_n_o    <= cpu_den_n;                // [RULE7]
      transceiver_enable_n_oe   <= drive;
      read_data_latch_strobe_o  <= ~cpu_rd_n;                // [RULE8]
      read_data_latch_strobe_oe <= drive;                    // [RULE19]
      bus_grant_out             <= cpu_hold_ack;             // [RULE19]
    end
  end

  // ----------------------------------------------------------------
  // Processor side returns
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_ad_in    <= BYTE_RST;
      cpu_ready    <= 1'b1;
      cpu_hold_req <= 1'b0;
      int_buf_en   <= 1'b1;
    end else begin
      if (rd_end) begin
        cpu_ad_in <= muxed_addr_data_byte_i;                 // [RULE8]
      end
      cpu_ready    <= pin_sync[PIN_ACK];                     // [RULE16] [RULE17]
      cpu_hold_req <= pin_sync[PIN_BUS_REQ];                 // [RULE18]
      int_buf_en   <= ~(win_hit_r & pin_sync[PIN_BUF_DIS]);  // [RULE9] [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // Link domain reset
  // ----------------------------------------------------------------
  logic lrst_s1_r;
  logic lrst_s2_r;

  always_ff @(posedge link_clk) begin
    lrst_s1_r <= rst_n;
    lrst_s2_r <= lrst_s1_r;
  end

  // ----------------------------------------------------------------
  // Window event crossing
  // ----------------------------------------------------------------
  logic win_tgl_l;
  logic win_tgl_d_r;
  logic win_event;

  xbp_sync3 u_win_sync (
    .clk   (link_clk),
    .rst_n (lrst_s2_r),
    .d_in  (win_tgl_r),
    .q_out (win_tgl_l)
  );

  assign win_event = win_tgl_l ^ win_tgl_d_r;

  // ----------------------------------------------------------------
  // Slow clock and window qualifier
  // ----------------------------------------------------------------
  logic [SLOW_CNT_W-1:0] slow_cnt_r;
  logic [SLOW_CNT_W-1:0] slow_cnt_nxt;
  logic                  slow_fall;
  logic                  win_pend_r;
  logic                  win_pend_nxt;

  assign slow_cnt_nxt = (slow_cnt_r == SLOW_PERIOD_CYC - 1'b1) ? '0
                        : slow_cnt_r + 1'b1;
  assign slow_fall    = (slow_cnt_r == SLOW_HIGH_CYC - 1'b1);
  assign win_pend_nxt = win_event | (win_pend_r & ~slow_fall);

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_r) begin
      slow_cnt_r              <= '0;
      slow_clock_out          <= 1'b0;
      win_tgl_d_r             <= 1'b0;
      win_pend_r              <= 1'b0;
      window_select_qualifier <= 1'b0;
    end else begin
      slow_cnt_r     <= slow_cnt_nxt;
      slow_clock_out <= (slow_cnt_nxt < SLOW_HIGH_CYC);      // [RULE15]
      win_tgl_d_r    <= win_tgl_l;
      win_pend_r     <= win_pend_nxt;
      if (slow_fall) begin
        window_select_qualifier <= win_pend_r | win_event;   // [RULE12] [RULE11]
      end
    end
  end

endmodule

// file: core/xbp_sync3.sv
`timescale 1ns/1ps
module xbp_sync3
  import xbp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level crossing
  input  wire logic d_in,
  output logic      q_out
);
  import xbp_pkg::*;

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------------------------------
  // Three stages, change accepted when stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      q_out <= 1'b0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_out <= s3_r;
      end
    end
  end

endmodule

// file: verif/system_expansion_bus_port_bench.sv
`timescale 1ns/1ps
module system_expansion_bus_port_bench;
  import xbp_pkg::*;
  // --------
  // Bench
  // --------
  logic        clk, link_clk, rst_n, cpu_ale, cpu_rd_n, cpu_wr_n, cpu_den_n;
  logic        cpu_dt_r, cpu_hold_ack, ext_buffer_disable_in, bus_request_in;
  logic        external_acknowledge_in, cpu_ready, cpu_hold_req, int_buf_en;
  logic        buffered_high_addr_oe, muxed_addr_data_byte_oe, ale_o, ale_oe;
  logic        rd_strobe_n_o, rd_strobe_n_oe, wr_strobe_n_o, wr_strobe_n_oe;
  logic        transceiver_enable_n_o, transceiver_enable_n_oe, bus_grant_out;
  logic        read_data_latch_strobe_o, read_data_latch_strobe_oe;
  logic        master_clock_out, cpu_phase_clock_out, slow_clock_out;
  logic        window_select_qualifier, force_dis, use_q, ack_wait, req;
  logic [11:0] cpu_high_addr, buffered_high_addr_o;
  logic [7:0]  cpu_ad_out, cpu_ad_in, muxed_addr_data_byte_i, rd_data;
  logic [7:0]  muxed_addr_data_byte_o, lat_addr;
  logic [31:0] rnd;
  logic [19:0] edge_a [4] = '{20'hE0000, 20'hEFFFF, 20'hDFFFF, 20'hF0000};
  int          n_mismatch, check_count, cyc, k, mc, pc, sc, ph;
  xbp_port        xbp_port_inst (.*);
  xbp_board_model xbp_board_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  function automatic logic in_win(logic [19:0] a);
    return a >= 20'hE0000 && a <= 20'hEFFFF;
  endfunction
  task automatic chk_v(string nm, logic [19:0] e, logic [19:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_n(string nm, int e, int g, int tol);
    check_count++;
    if (g < e - tol || g > e + tol) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_q(logic v);
    for (k = 0; k < 800 && window_select_qualifier !== v; k++) @(posedge clk);
  endtask
  task automatic bus_cyc(logic [19:0] a, logic [7:0] d, bit rd);
    cpu_high_addr <= a[19:8];
    cpu_ad_out <= a[7:0];
    cpu_ale <= 1'b1;
    @(posedge clk);
    cpu_ale <= 1'b0;
    cpu_ad_out <= d;
    rd_data <= d;
    cpu_dt_r <= !rd;
    @(posedge clk);
    cpu_den_n <= 1'b0;
    cpu_rd_n <= !rd;
    cpu_wr_n <= rd;
    tick(3);
    #1;
    chk_v("high addr", a[19:8], buffered_high_addr_o);
    chk_v("latched low addr", a[7:0], lat_addr);
    chk_v("read strobe", !rd, rd_strobe_n_o);
    chk_v("write strobe", rd, wr_strobe_n_o);
    chk_v("data enable", 0, transceiver_enable_n_o);
    @(posedge clk);
    {cpu_rd_n, cpu_wr_n, cpu_den_n} <= 3'b111;
    tick(2);
    #1;
    if (rd) chk_v("read data", d, cpu_ad_in);
  endtask
  initial begin
    {cpu_high_addr, cpu_ad_out, cpu_ale, cpu_dt_r, cpu_hold_ack} = '0;
    {cpu_rd_n, cpu_wr_n, cpu_den_n} = 3'b111;
    {rd_data, force_dis, use_q, ack_wait, req} = '0;
    rst_n = 1'b0;
    void'($urandom(55684));
    tick(12);
    rst_n <= 1'b1;
    tick(2);
    repeat (20) begin
      rnd = $urandom;
      bus_cyc(rnd[19:0], rnd[27:20], rnd[31]);
    end
    force_dis <= 1'b1;
    foreach (edge_a[i]) begin
      bus_cyc(edge_a[i], 8'h5A, 1'b0);
      tick(8);
      #1;
      chk_v("buffer enable", !in_win(edge_a[i]), int_buf_en);
    end
    force_dis <= 1'b0;
    use_q <= 1'b1;
    wait_q(1'b0);
    bus_cyc(20'hE1234, 8'hC3, 1'b1);
    wait_q(1'b1);
    chk_v("qualifier", 1, window_select_qualifier);
    tick(12);
    #1;
    chk_v("buffer enable", 0, int_buf_en);
    wait_q(1'b0);
    chk_n("qualifier width", 248, k + 12, 2);
    use_q <= 1'b0;
    ack_wait <= 1'b1;
    tick(2);
    #1;
    chk_v("ready resync", 1, cpu_ready);
    tick(5);
    #1;
    chk_v("ready wait", 0, cpu_ready);
    ack_wait <= 1'b0;
    req <= 1'b1;
    tick(7);
    #1;
    chk_v("ready back", 1, cpu_ready);
    chk_v("hold request", 1, cpu_hold_req);
    cpu_hold_ack <= 1'b1;
    tick(2);
    #1;
    chk_v("grant", 1, bus_grant_out);
    chk_v("high addr oe", 0, buffered_high_addr_oe);
    chk_v("bus oes", 0, {muxed_addr_data_byte_oe, ale_oe, rd_strobe_n_oe,
      wr_strobe_n_oe, transceiver_enable_n_oe, read_data_latch_strobe_oe});
    {cpu_hold_ack, req} <= 2'b00;
    {mc, pc, sc, ph} = '0;
    for (int i = 0; i < 2500; i++) begin
      rnd[2:0] = {master_clock_out, cpu_phase_clock_out, slow_clock_out};
      @(posedge clk);
      #1;
      mc += master_clock_out & !rnd[2];
      pc += cpu_phase_clock_out & !rnd[1];
      sc += slow_clock_out & !rnd[0];
      ph += cpu_phase_clock_out;
    end
    chk_n("master edges", int'(10000.0 / 66.6), mc, 1);
    chk_n("phase edges", int'(10000.0 / 200.0), pc, 1);
    chk_n("phase high", 2500 / 3, ph, 10);
    chk_n("slow edges", 10, sc, 1);
    end_sim();
  end
endmodule

// file: verif/xbp_board_model.sv
`timescale 1ns/1ps
module xbp_board_model (
  // Design outputs
  input  logic       clk,
  input  logic [7:0] muxed_addr_data_byte_o,
  input  logic       muxed_addr_data_byte_oe,
  input  logic       ale_o,
  input  logic       rd_strobe_n_o,
  input  logic       transceiver_enable_n_o,
  input  logic       window_select_qualifier,
  // Bench controls
  input  logic [7:0] rd_data,
  input  logic       force_dis,
  input  logic       use_q,
  input  logic       ack_wait,
  input  logic       req,
  // Board drives
  output logic [7:0] muxed_addr_data_byte_i,
  output logic       ext_buffer_disable_in,
  output logic       external_acknowledge_in,
  output logic       bus_request_in,
  output logic [7:0] lat_addr
);
  // --------
  // Board
  // --------
  logic [7:0] last_r = 8'h00;
  logic       drive;
  assign drive = !transceiver_enable_n_o && !rd_strobe_n_o;
  // Released lanes toggle every cycle, except while the board drives rd_data during a read
  assign muxed_addr_data_byte_i = muxed_addr_data_byte_oe ?
    muxed_addr_data_byte_o : (drive ? rd_data : ~last_r);
  assign ext_buffer_disable_in = force_dis | (use_q & window_select_qualifier);
  assign external_acknowledge_in = !ack_wait;
  assign bus_request_in = req;
  always_ff @(posedge clk) begin
    last_r <= muxed_addr_data_byte_i;
    if (ale_o) begin
      lat_addr <= muxed_addr_data_byte_i;
    end
  end
endmodule

// file: verif/xbp_port_props.sv
`timescale 1ns/1ps
module xbp_port_props (
  // Clocks and processor side
  input logic        clk,
  input logic        rst_n,
  input logic        link_clk,
  input logic [11:0] cpu_high_addr,
  input logic [7:0]  cpu_ad_out,
  input logic        cpu_ale,
  input logic        cpu_rd_n,
  input logic        cpu_wr_n,
  input logic        cpu_hold_ack,
  input logic [7:0]  cpu_ad_in,
  input logic        cpu_ready,
  // Board side
  input logic [11:0] buffered_high_addr_o,
  input logic        buffered_high_addr_oe,
  input logic [7:0]  muxed_addr_data_byte_i,
  input logic [7:0]  muxed_addr_data_byte_o,
  input logic        muxed_addr_data_byte_oe,
  input logic        ale_oe,
  input logic        rd_strobe_n_o,
  input logic        wr_strobe_n_o,
  input logic        read_data_latch_strobe_o,
  input logic        slow_clock_out,
  input logic        window_select_qualifier,
  input logic        external_acknowledge_in
);
  // --------
  // Checks
  // --------
  property p_hi_hold;
    @(posedge clk) disable iff (!rst_n)
      !cpu_ale && !$past(cpu_ale) |-> $stable(buffered_high_addr_o);
  endproperty
  a_hi_hold: assert property (p_hi_hold)
    else $error("high address moved");
  property p_float;
    @(posedge clk) disable iff (!rst_n) cpu_hold_ack |=>
      !buffered_high_addr_oe && !muxed_addr_data_byte_oe && !ale_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("bus driven during grant");
  property p_lane;
    @(posedge clk) disable iff (!rst_n) cpu_ale && !cpu_hold_ack |=>
      muxed_addr_data_byte_oe && muxed_addr_data_byte_o == $past(cpu_ad_out);
  endproperty
  a_lane: assert property (p_lane)
    else $error("low address not on lanes");
  property p_rd;
    @(posedge clk) disable iff (!rst_n) !cpu_rd_n |=> !rd_strobe_n_o;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read strobe missing");
  property p_wr;
    @(posedge clk) disable iff (!rst_n) !cpu_wr_n |=> !wr_strobe_n_o;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write strobe missing");
  property p_latch;
    @(posedge clk) disable iff (!rst_n) $rose(cpu_rd_n) |=>
      !read_data_latch_strobe_o && cpu_ad_in == $past(muxed_addr_data_byte_i);
  endproperty
  a_latch: assert property (p_latch)
    else $error("read data not latched");
  property p_ready;
    @(posedge clk) disable iff (!rst_n)
      $fell(external_acknowledge_in) && cpu_ready |=>
      cpu_ready [*2] ##[1:4] !cpu_ready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("wait state timing wrong");
  property p_qual;
    @(posedge link_clk) disable iff (!rst_n)
      $rose(window_select_qualifier) |-> $fell(slow_clock_out);
  endproperty
  a_qual: assert property (p_qual)
    else $error("qualifier off slow clock fall");
endmodule
bind xbp_port xbp_port_props xbp_port_props_inst (.*);
